// ---- dcs_channel.v ----
// Purpose: Suspend, resume and event control of one DMA channel.
// Assumes: The transfer engine reports burst ends, block ends, descriptor
//          fetches and AHB access ends as one-cycle pulses on CORE_CLK.
// Notes:   Registers sit behind an AXI4-Lite slave that answers one cycle
//          after it has both halves of a write, or the read address.
`timescale 1ns/1ps
`include "dcs_defines.vh"

// Function
// R1 - Suspend command halts after the current burst and clears the command.
// R2 - Entering suspension sets halted flag and optional suspend interrupt.
// R3 - Block action 0x2 or 0x3 suspends after the block completes.
// R4 - Block-suspended channel stays enabled, keeps triggers, leaves arbitration.
// R5 - Descriptor with ok bit 0 suspends and sets fetch fault bit.
// R6 - Suspend requests on a disabled channel are ignored.
// R7 - Resume on a suspended channel continues where it stopped.
// R8 - Early resume is remembered and skips the next suspend; code skips only the next block suspend.
// R9 - Software enables event input and routing before using event actions.
// R10 - Action select chooses the event mode; trigger source picks normal or strobe.
// R11 - Normal mode acks at once, sets waiting bits, drops event when pending.
// R12 - Strobe mode acks at once, registers trigger only with event, not pending.
// R13 - Event plus trigger set waiting bits; software trigger starts transfer.
// R14 - Conditional mode latches trigger on event, sets waiting bits, acks.
// R15 - Block mode waits for an event, acks it when the block completes.
// R16 - Suspend event halts channel, ack after current AHB access finishes.
// R17 - Resume event resumes channel, acks at once, clears halted flag.
// R18 - Bypass event resumes a halted channel or skips the next block suspend.
// R19 - Event outputs are exactly one clock cycle pulses.
// R20 - Software relinks inserted descriptors with the ok bit cleared.
// R21 - Software edits listed descriptors via suspend and write-back patch.
// R22 - Null next pointer after resume suspends with halted and fault bits.
// R23 - Only one pending request per channel; extra ones are discarded.
// R24 - Event suspend and resume use the software suspend machinery.
module dcs_channel (
  input  wire        CORE_CLK,
  input  wire        RESET,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        EVENT_IN,
  output reg         EVENT_ACK,
  input  wire        PERIPH_EVENT_BEAT_LAUNCH,
  input  wire        BURST_DONE,
  input  wire        BLOCK_DONE,
  input  wire        BEAT_DONE,
  input  wire        AHB_ACCESS_DONE,
  input  wire        DESC_FETCHED,
  input  wire        DESC_OK,
  input  wire [1:0]  DESC_BLOCK_ACTION,
  input  wire [31:0] DESC_NEXT_PTR,
  input  wire        TRANSFER_START,
  output reg         ARB_ELIGIBLE,
  output reg         SUSPEND_IRQ,
  output reg         EVENT_OUT
);

  // -------------------------------------------------------------------------
  // Channel states
  // -------------------------------------------------------------------------
  localparam [1:0] ST_IDLE    = 2'd0;
  localparam [1:0] ST_RUN     = 2'd1;
  localparam [1:0] ST_DRAIN   = 2'd2;
  localparam [1:0] ST_HALTED  = 2'd3;

  reg  [1:0]  state;
  reg  [31:0] ctrl;
  reg         waiting;
  reg         halted_flag;
  reg         fetch_fault;
  reg         skip_next;
  reg         ev_held;
  reg         seg_open;
  reg         seg_ack_due;
  reg         ev_susp_ack_due;
  reg         resumed;
  reg         ev_s1;
  reg         ev_s2;
  reg         ev_s3;
  reg         ev_level;
  reg         tr_s1;
  reg         tr_s2;
  reg         tr_s3;
  reg         event_beat_launch_level;
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire        enabled   = ctrl[`DCS_CTRL_ENABLE];
  wire [1:0]  cmd       = ctrl[`DCS_CTRL_CMD_HI:`DCS_CTRL_CMD_LO];
  wire        ev_en     = ctrl[`DCS_CTRL_EVIE];
  wire [2:0]  evact     = ctrl[`DCS_CTRL_EVACT_HI:`DCS_CTRL_EVACT_LO];
  wire        periph_src = ctrl[`DCS_CTRL_TRGSRC];

  // -------------------------------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ev_s1      <= 1'b0;
      ev_s2      <= 1'b0;
      ev_s3      <= 1'b0;
      ev_level   <= 1'b0;
      tr_s1      <= 1'b0;
      tr_s2      <= 1'b0;
      tr_s3      <= 1'b0;
      event_beat_launch_level <= 1'b0;
    end else begin
      ev_s1 <= EVENT_IN;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      tr_s1 <= PERIPH_EVENT_BEAT_LAUNCH;
      tr_s2 <= tr_s1;
      tr_s3 <= tr_s2;
      if (ev_s2 == ev_s3)
        ev_level <= ev_s3;
      if (tr_s2 == tr_s3)
        event_beat_launch_level <= tr_s3;
    end
  end

  reg ev_prev;
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET)
      ev_prev <= 1'b0;
    else
      ev_prev <= ev_level;
  end
  wire ev_rise = ev_level & ~ev_prev & ev_en & enabled;

  // -------------------------------------------------------------------------
  // AXI4-Lite slave
  // -------------------------------------------------------------------------
  assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
  assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  wire do_write = aw_held & w_held & ~S_AXI_BVALID;
  wire wr_ctrl  = do_write & (aw_addr == `DCS_OFS_CTRL);
  wire wr_flags = do_write & (aw_addr == `DCS_OFS_FLAGS);
  wire wr_event_beat_launch  = do_write & (aw_addr == `DCS_OFS_SWTRIG) & w_data[0]
                  & w_strb[0];
  wire wr_map   = (aw_addr == `DCS_OFS_CTRL) | (aw_addr == `DCS_OFS_STATUS)
                  | (aw_addr == `DCS_OFS_FLAGS)
                  | (aw_addr == `DCS_OFS_WAITING)
                  | (aw_addr == `DCS_OFS_SWTRIG);

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[11:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_map ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  wire [31:0] status_word = {26'h000_0000, ev_held, skip_next, halted_flag,
                             fetch_fault, (state == ST_RUN), waiting};

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= 2'h0;
      if (S_AXI_ARADDR[11:2] == `DCS_OFS_CTRL >> 2)
        S_AXI_RDATA <= ctrl;
      else if (S_AXI_ARADDR[11:2] == `DCS_OFS_STATUS >> 2)
        S_AXI_RDATA <= status_word;
      else if (S_AXI_ARADDR[11:2] == `DCS_OFS_FLAGS >> 2)
        S_AXI_RDATA <= {31'h0000_0000, halted_flag};
      else if (S_AXI_ARADDR[11:2] == `DCS_OFS_WAITING >> 2)
        S_AXI_RDATA <= {31'h0000_0000, waiting};
      else if (S_AXI_ARADDR[11:2] == `DCS_OFS_SWTRIG >> 2)
        S_AXI_RDATA <= 32'h0000_0000;
      else begin
        S_AXI_RDATA <= 32'h0000_0000;
        S_AXI_RRESP <= 2'h2;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Suspend sources
  // -------------------------------------------------------------------------
  wire ev_beat    = ev_rise & (evact == `DCS_EV_BEAT);
  wire ev_susp    = ev_rise & (evact == `DCS_EV_SUSPEND);
  wire ev_resume  = ev_rise & (evact == `DCS_EV_RESUME);
  wire ev_bypass  = ev_rise & (evact == `DCS_EV_BYPASS);
  wire blk_susp   = BLOCK_DONE & ((DESC_BLOCK_ACTION == `DCS_BLKACT_SUSP) |
                    (DESC_BLOCK_ACTION == `DCS_BLKACT_BOTH)); // R3
  wire bad_desc   = DESC_FETCHED & (~DESC_OK |
                    (resumed & (DESC_NEXT_PTR == `DCS_NULL_PTR))); // R5 R22
  wire sw_susp    = (cmd == `DCS_CMD_SUSPEND);
  wire sw_resume  = (cmd == `DCS_CMD_RESUME);
  wire any_resume = sw_resume | ev_resume
                    | (ev_bypass & (state == ST_HALTED)); // R24
  wire skip_now   = skip_next | ev_held;
  wire blk_halt   = blk_susp & ~skip_now;

  // -------------------------------------------------------------------------
  // Channel suspend state machine
  // -------------------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state           <= ST_IDLE;
      ctrl            <= `DCS_CTRL_RESET;
      halted_flag     <= 1'b0;
      fetch_fault     <= 1'b0;
      skip_next       <= 1'b0;
      ev_held         <= 1'b0;
      ev_susp_ack_due <= 1'b0;
      resumed         <= 1'b0;
    end else begin
      if (wr_ctrl)
        ctrl <= w_data;
      if (wr_flags && w_data[0])
        halted_flag <= 1'b0;
      if (bad_desc)
        resumed <= 1'b0;
      if (!enabled) begin
        state <= ST_IDLE; // R6
        skip_next <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_RUN;
          end
          ST_RUN: begin
            if (bad_desc) begin
              state       <= ST_HALTED; // R5
              halted_flag <= 1'b1;
              fetch_fault <= 1'b1;
            end else if (blk_halt) begin
              state       <= ST_HALTED; // R3 R4
              halted_flag <= 1'b1;
            end else if (sw_susp || ev_susp) begin
              state <= ST_DRAIN; // R1 R16 R24
            end else if (sw_resume) begin
              skip_next <= 1'b1; // R8
              ctrl[`DCS_CTRL_CMD_HI:`DCS_CTRL_CMD_LO] <= `DCS_CMD_NONE;
            end
            if (blk_susp && skip_now)
              skip_next <= 1'b0; // R8
          end
          ST_DRAIN: begin
            if (BURST_DONE) begin
              state       <= ST_HALTED; // R1 R2
              halted_flag <= 1'b1;
              ctrl[`DCS_CTRL_CMD_HI:`DCS_CTRL_CMD_LO] <= `DCS_CMD_NONE;
            end
          end
          ST_HALTED: begin
            if (any_resume) begin
              state       <= ST_RUN; // R7
              resumed     <= 1'b1;
              fetch_fault <= 1'b0;
              ctrl[`DCS_CTRL_CMD_HI:`DCS_CTRL_CMD_LO] <= `DCS_CMD_NONE;
              if (ev_resume)
                halted_flag <= 1'b0; // R17
            end else if (sw_susp) begin
              ctrl[`DCS_CTRL_CMD_HI:`DCS_CTRL_CMD_LO] <= `DCS_CMD_NONE;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      if (ev_susp && enabled)
        ev_susp_ack_due <= 1'b1;
      else if (AHB_ACCESS_DONE)
        ev_susp_ack_due <= 1'b0;
      if (ev_bypass && state != ST_HALTED)
        ev_held <= 1'b1; // R18
      else if (BLOCK_DONE)
        ev_held <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // Pending request and event acknowledge
  // -------------------------------------------------------------------------
  wire beat_norm  = ev_beat & ~periph_src; // R10
  wire beat_gate  = ev_beat & periph_src & event_beat_launch_level;
  wire gated_launch      = ev_rise & (evact == `DCS_EV_GATED) & event_beat_launch_level;
  wire plain_event_beat_launch = event_beat_launch_level & ~ev_en;
  wire set_wait   = beat_norm | beat_gate | gated_launch | wr_event_beat_launch | plain_event_beat_launch;

  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      waiting     <= 1'b0;
      seg_open    <= 1'b0;
      seg_ack_due <= 1'b0;
      EVENT_ACK   <= 1'b0;
    end else begin
      if (!waiting && set_wait)
        waiting <= 1'b1; // R11 R12 R13 R14 R23
      else if (TRANSFER_START)
        waiting <= 1'b0;
      if (ev_rise && evact == `DCS_EV_SEGMENT)
        seg_open <= 1'b1; // R15
      else if (BLOCK_DONE)
        seg_open <= 1'b0;
      seg_ack_due <= BLOCK_DONE & seg_open;
      EVENT_ACK <= beat_norm | (ev_beat & periph_src)
                   | (gated_launch & ~waiting) | seg_ack_due
                   | (ev_susp_ack_due & AHB_ACCESS_DONE)
                   | ev_resume | (ev_bypass & (state == ST_HALTED))
                   | (ev_held & BLOCK_DONE); // R11 R12 R14 R15 R16 R17 R18
    end
  end

  // -------------------------------------------------------------------------
  // Arbitration, interrupt and event output
  // -------------------------------------------------------------------------
  always @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ARB_ELIGIBLE <= 1'b0;
      SUSPEND_IRQ  <= 1'b0;
      EVENT_OUT    <= 1'b0;
    end else begin
      ARB_ELIGIBLE <= enabled & waiting & (state == ST_RUN)
                      & (seg_open | ~ev_en | evact != `DCS_EV_SEGMENT); // R15
      SUSPEND_IRQ  <= halted_flag & ctrl[`DCS_CTRL_SUSPIE]; // R2
      EVENT_OUT    <= ctrl[`DCS_CTRL_EVOE] & (BLOCK_DONE | BEAT_DONE); // R19
    end
  end

endmodule // dcs_channel

// ---- dcs_channel_sva.sv ----
// Purpose: Port-level checks of the channel suspend and event block.
// Assumes: Bound to dcs_channel from the bench top file.
// Notes:   Only signals driven by the block are judged.
`timescale 1ns/1ps
module dcs_channel_sva (
  input wire        CORE_CLK,
  input wire        RESET,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire        EVENT_ACK,
  input wire        EVENT_OUT,
  input wire        BLOCK_DONE,
  input wire        BEAT_DONE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // -------------------------------------------------------------------------
  // Bus handshakes
  // -------------------------------------------------------------------------
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  a_write_answer: assert property (wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (rd_take |-> ##1 S_AXI_RVALID)
    else $error("read data missing");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_write_refuse: assert property (S_AXI_BVALID |->
    !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response open");
  a_read_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while data open");
  // -------------------------------------------------------------------------
  // Event pulses
  // -------------------------------------------------------------------------
  a_evout_width: assert property (EVENT_OUT |=> !EVENT_OUT)
    else $error("event output wider than one cycle");
  a_evout_cause: assert property (EVENT_OUT |->
    $past(BLOCK_DONE) || $past(BEAT_DONE))
    else $error("event output without a transfer end");
  a_ack_width: assert property (EVENT_ACK |=> !EVENT_ACK)
    else $error("event acknowledge wider than one cycle");
endmodule // dcs_channel_sva

// ---- dcs_defines.vh ----
// Purpose: Constants for the DMA channel suspend and event control block.
// Assumes: Included by the design file by its bare name.
// Notes:   Offsets are byte addresses on the AXI4-Lite register bus.
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define DCS_OFS_CTRL      12'h000
`define DCS_OFS_STATUS    12'h004
`define DCS_OFS_FLAGS     12'h008
`define DCS_OFS_WAITING   12'h00c
`define DCS_OFS_SWTRIG    12'h010

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define DCS_CTRL_ENABLE   0
`define DCS_CTRL_CMD_LO   1
`define DCS_CTRL_CMD_HI   2
`define DCS_CTRL_EVIE     3
`define DCS_CTRL_EVACT_LO 4
`define DCS_CTRL_EVACT_HI 6
`define DCS_CTRL_TRGSRC   7
`define DCS_CTRL_EVOE     8
`define DCS_CTRL_SUSPIE   9
`define DCS_CTRL_RESET    32'h0000_0000

// ---------------------------------------------------------------------------
// Status and flag bits
// ---------------------------------------------------------------------------
`define DCS_ST_WAITING    0
`define DCS_ST_BUSY       1
`define DCS_ST_FAULT      2
`define DCS_ST_HALTED     3
`define DCS_ST_SKIP       4
`define DCS_ST_EVHELD     5

// ---------------------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------------------
`define DCS_CMD_NONE      2'h0
`define DCS_CMD_SUSPEND   2'h1
`define DCS_CMD_RESUME    2'h2

// ---------------------------------------------------------------------------
// Event actions
// ---------------------------------------------------------------------------
`define DCS_EV_IGNORED    3'h0
`define DCS_EV_BEAT       3'h1
`define DCS_EV_GATED      3'h2
`define DCS_EV_SEGMENT    3'h3
`define DCS_EV_SUSPEND    3'h4
`define DCS_EV_RESUME     3'h5
`define DCS_EV_BYPASS     3'h6

// ---------------------------------------------------------------------------
// Descriptor fields
// ---------------------------------------------------------------------------
`define DCS_BLKACT_SUSP   2'h2
`define DCS_BLKACT_BOTH   2'h3
`define DCS_NULL_PTR      32'h0000_0000

`endif

// ---- dcs_partner.sv ----
// Purpose: Event source, peripheral trigger and transfer engine model.
// Assumes: The bench calls one task at a time.
// Notes:   Descriptor lines carry inverted data outside their pulse.
`timescale 1ns/1ps
module dcs_partner (
  input  wire        clk,
  output reg         ev_in,
  output reg         event_beat_launch,
  output reg         burst,
  output reg         block,
  output reg         beat,
  output reg         ahb,
  output reg         fetch,
  output reg         start,
  output reg         ok,
  output reg  [1:0]  act,
  output reg  [31:0] ptr
);
  initial begin
    {start, fetch, ahb, beat, block, burst, ev_in, event_beat_launch} = 8'h00;
    {ok, act, ptr} = 35'h0;
  end
  // The event stays low long enough for the input sync to see a new rise.
  task ev_pulse;
    begin
      @(posedge clk);
      ev_in <= 1'b1;
      repeat (4) @(posedge clk);
      ev_in <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  task set_event_beat_launch(input v);
    begin
      @(posedge clk);
      event_beat_launch <= v;
      repeat (6) @(posedge clk);
    end
  endtask
  // Kinds: 0 burst, 1 block, 2 beat, 3 bus access, 4 fetch, 5 start.
  task eng(input [2:0] k, input o, input [1:0] a, input [31:0] p);
    begin
      @(posedge clk);
      {ok, act, ptr} <= {o, a, p};
      {start, fetch, ahb, beat, block, burst} <= 6'h01 << k;
      @(posedge clk);
      {start, fetch, ahb, beat, block, burst} <= 6'h00;
      {ok, act, ptr} <= ~{o, a, p};
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // dcs_partner

// ---- dma_channel_suspend_event_ctrl_bench.sv ----
// Purpose: Self-checking bench for the channel suspend and event block.
// Assumes: The partner model supplies events, triggers and engine pulses.
// Notes:   Registers are reached through AXI4-Lite tasks.
`timescale 1ns/1ps
`include "dcs_defines.vh"
module dma_channel_suspend_event_ctrl_bench;
  localparam [11:0] CT = `DCS_OFS_CTRL;
  localparam [11:0] ST = `DCS_OFS_STATUS;
  localparam [11:0] FL = `DCS_OFS_FLAGS;
  localparam [11:0] WT = `DCS_OFS_WAITING;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] awa = 12'h000;
  reg  [11:0] ara = 12'h000;
  reg  [31:0] wd = 32'h0;
  reg         awv = 1'b0;
  reg         wv = 1'b0;
  reg         bre = 1'b0;
  reg         arv = 1'b0;
  reg         rre = 1'b0;
  reg  [31:0] nack = 32'h0;
  reg  [31:0] nevo = 32'h0;
  reg  [31:0] ea = 32'h0;
  reg  [31:0] d;
  reg  [1:0]  r;
  int         n_errors = 0;
  int         total_checks = 0;
  wire        awr, wrd, bv, arr, rv, ack, elig, irq, evo;
  wire        evi, ptg, bud, bld, btd, ahd, dfe, dok, tst;
  wire [1:0]  brs, rrs, dba;
  wire [31:0] rd, dnp;
  always #2 clk = ~clk;
  always @(posedge clk) if (ack === 1'b1) nack <= nack + 1;
  always @(posedge clk) if (evo === 1'b1) nevo <= nevo + 1;
  dcs_channel dut_u (.CORE_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
    .S_AXI_BRESP(brs), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rrs), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .EVENT_IN(evi), .EVENT_ACK(ack),
    .PERIPH_EVENT_BEAT_LAUNCH(ptg), .BURST_DONE(bud), .BLOCK_DONE(bld),
    .BEAT_DONE(btd), .AHB_ACCESS_DONE(ahd), .DESC_FETCHED(dfe),
    .DESC_OK(dok), .DESC_BLOCK_ACTION(dba), .DESC_NEXT_PTR(dnp),
    .TRANSFER_START(tst), .ARB_ELIGIBLE(elig), .SUSPEND_IRQ(irq),
    .EVENT_OUT(evo));
  dcs_partner p_u (.clk(clk), .ev_in(evi), .event_beat_launch(ptg), .burst(bud),
    .block(bld), .beat(btd), .ahb(ahd), .fetch(dfe), .start(tst),
    .ok(dok), .act(dba), .ptr(dnp));
  // -------------------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------------------
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      total_checks++;
      if (g !== e) begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task axi_wr(input [11:0] a, input [31:0] v);
    int n;
    begin
      n = 0;
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
        @(posedge clk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wrd) wv <= 1'b0;
        n++;
      end while ((awv || wv) && n < 64);
      while (bv !== 1'b1 && n < 64) begin
        @(posedge clk);
        n++;
      end
      bre <= 1'b0;
      if (n >= 64) n_errors++;
    end
  endtask
  task axi_rd(input [11:0] a, output [31:0] v, output [1:0] rs);
    int n;
    begin
      n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
        @(posedge clk);
        n++;
      end while (arr !== 1'b1 && n < 64);
      arv <= 1'b0;
      while (rv !== 1'b1 && n < 64) begin
        @(posedge clk);
        n++;
      end
      v = rd;
      rs = rrs;
      rre <= 1'b0;
      if (n >= 64) n_errors++;
    end
  endtask
  task rdm(input string nm, input [11:0] a, input [31:0] m,
           input [31:0] e);
    reg [31:0] v;
    reg [1:0]  rs;
    begin
      axi_rd(a, v, rs);
      chk(nm, e & m, v & m);
    end
  endtask
  task ev_ack(input string nm);
    begin
      p_u.ev_pulse;
      ea = ea + 1;
      chk(nm, ea, nack);
    end
  endtask
  task print_verdict;
    begin
      if (n_errors == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  // -------------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdm("ctrl", CT, 32'hffffffff, `DCS_CTRL_RESET);
    axi_rd(12'h020, d, r);
    chk("bad_resp", 32'h2, {30'h0, r});
    axi_wr(CT, 32'h201);
    axi_wr(CT, 32'h203);
    rdm("early", ST, 32'h8, 32'h0);
    p_u.eng(3'd0, 1'b1, 2'd0, 32'h100);
    rdm("susp", ST, 32'h8, 32'h8);
    rdm("cmd", CT, 32'h6, 32'h0);
    rdm("flag", FL, 32'h1, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    axi_wr(CT, 32'h205);
    rdm("resume", ST, 32'h2, 32'h2);
    axi_wr(FL, 32'h1);
    rdm("flag_clr", FL, 32'h1, 32'h0);
    chk("irq_off", 32'h0, {31'h0, irq});
    axi_wr(CT, 32'h205);
    rdm("skip", ST, 32'h10, 32'h10);
    p_u.eng(3'd1, 1'b1, `DCS_BLKACT_SUSP, 32'h100);
    rdm("skipped", ST, 32'h18, 32'h0);
    p_u.eng(3'd1, 1'b1, `DCS_BLKACT_BOTH, 32'h100);
    rdm("blk_susp", ST, 32'h8, 32'h8);
    axi_wr(`DCS_OFS_SWTRIG, 32'h1);
    axi_wr(`DCS_OFS_SWTRIG, 32'h1);
    rdm("event_beat_launch_kept", WT, 32'h1, 32'h1);
    chk("no_arb", 32'h0, {31'h0, elig});
    axi_wr(CT, 32'h205);
    rdm("run", ST, 32'h2, 32'h2);
    chk("arb", 32'h1, {31'h0, elig});
    p_u.eng(3'd5, 1'b1, 2'd0, 32'h100);
    rdm("one_pend", WT, 32'h1, 32'h0);
    p_u.eng(3'd4, 1'b0, 2'd0, 32'h100);
    rdm("bad_desc", ST, 32'hc, 32'hc);
    axi_wr(CT, 32'h205);
    rdm("fault_clr", ST, 32'h6, 32'h2);
    p_u.eng(3'd4, 1'b1, 2'd0, `DCS_NULL_PTR);
    rdm("null_ptr", ST, 32'hc, 32'hc);
    axi_wr(CT, 32'h205);
    axi_wr(FL, 32'h1);
    axi_wr(CT, 32'h0);
    axi_wr(CT, 32'h2);
    p_u.eng(3'd0, 1'b1, 2'd0, 32'h100);
    rdm("disabled", ST, 32'h8, 32'h0);
    rdm("no_flag", FL, 32'h1, 32'h0);
    axi_wr(CT, 32'h219);
    ev_ack("ack_beat");
    rdm("pend", WT, 32'h1, 32'h1);
    ev_ack("ack_drop");
    p_u.eng(3'd5, 1'b1, 2'd0, 32'h100);
    rdm("dropped", WT, 32'h1, 32'h0);
    axi_wr(CT, 32'h299);
    p_u.set_event_beat_launch(1'b1);
    rdm("no_event", WT, 32'h1, 32'h0);
    ev_ack("ack_strobe");
    rdm("strobe", WT, 32'h1, 32'h1);
    p_u.set_event_beat_launch(1'b0);
    p_u.eng(3'd5, 1'b1, 2'd0, 32'h100);
    axi_wr(CT, 32'h229);
    p_u.set_event_beat_launch(1'b1);
    rdm("no_latch", WT, 32'h1, 32'h0);
    ev_ack("ack_gated");
    rdm("latched", WT, 32'h1, 32'h1);
    p_u.set_event_beat_launch(1'b0);
    p_u.eng(3'd5, 1'b1, 2'd0, 32'h100);
    axi_wr(CT, 32'h239);
    p_u.ev_pulse;
    chk("ack_wait", ea, nack);
    p_u.eng(3'd1, 1'b1, 2'd0, 32'h100);
    ea = ea + 1;
    chk("ack_blk", ea, nack);
    axi_wr(CT, 32'h249);
    p_u.ev_pulse;
    chk("ack_hold", ea, nack);
    p_u.eng(3'd3, 1'b1, 2'd0, 32'h100);
    ea = ea + 1;
    chk("ack_susp", ea, nack);
    p_u.eng(3'd0, 1'b1, 2'd0, 32'h100);
    rdm("ev_susp", ST, 32'h8, 32'h8);
    axi_wr(CT, 32'h259);
    ev_ack("ack_res");
    rdm("ev_res", ST, 32'h2, 32'h2);
    rdm("ev_flag", FL, 32'h1, 32'h0);
    axi_wr(CT, 32'h269);
    p_u.ev_pulse;
    rdm("held", ST, 32'h20, 32'h20);
    chk("ack_held", ea, nack);
    p_u.eng(3'd1, 1'b1, `DCS_BLKACT_SUSP, 32'h100);
    ea = ea + 1;
    chk("ack_skip", ea, nack);
    rdm("no_halt", ST, 32'h28, 32'h0);
    p_u.eng(3'd1, 1'b1, `DCS_BLKACT_SUSP, 32'h100);
    rdm("halt2", ST, 32'h8, 32'h8);
    ev_ack("ack_bp");
    rdm("bp_res", ST, 32'h2, 32'h2);
    axi_wr(CT, 32'h101);
    p_u.eng(3'd2, 1'b1, 2'd0, 32'h100);
    p_u.eng(3'd1, 1'b1, 2'd0, 32'h100);
    chk("evout", 32'h2, nevo);
    print_verdict;
  end
endmodule // dma_channel_suspend_event_ctrl_bench

bind dcs_channel dcs_channel_sva chk_u (.CORE_CLK(CORE_CLK), .RESET(RESET),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .EVENT_ACK(EVENT_ACK), .EVENT_OUT(EVENT_OUT), .BLOCK_DONE(BLOCK_DONE),
  .BEAT_DONE(BEAT_DONE));
